// ### src/lcd_cmd_pkg.sv
package lcd_cmd_pkg;

  // ****************************************************************
  // host port encodings and framing
  // ****************************************************************
  localparam logic [2:0] IM_PAR18   = 3'h0;  // interface mode strap codes
  localparam logic [2:0] IM_PAR16   = 3'h1;
  localparam logic [2:0] IM_PAR9    = 3'h2;
  localparam logic [2:0] IM_PAR8    = 3'h3;
  localparam logic [2:0] IM_SERIAL  = 3'h4;
  localparam int         PIN_W      = 26;    // synchronised pin bundle width
  localparam logic [4:0] SPI_HDR_LAST   = 5'h07;  // last bit of start byte
  localparam logic [4:0] SPI_WORD_LAST  = 5'h17;  // last bit of a data word
  localparam logic [4:0] SPI_WORD_FIRST = 5'h08;  // first data bit position
  localparam logic [5:0] SPI_START_ID   = 6'h1c;  // start byte id field
  // arbitrary identification value, not tied to any real part
  localparam logic [15:0] ID_CODE   = 16'h5a5a;

  // ****************************************************************
  // control register map
  // ****************************************************************
  localparam int         NREG       = 46;
  localparam logic [7:0] OFS_ID     = 8'h00;
  localparam logic [7:0] OFS_DRV_DIR = 8'h01;
  localparam int         IDX_DRV    = 0;     // driver_output_direction
  localparam int         IDX_ENTRY  = 2;     // entry_mode
  localparam int         IDX_GATE   = 33;    // gate_scan_control
  localparam int         SS_BIT     = 8;     // source shift direction
  localparam int         SM_BIT     = 10;    // gate_interlace_scan
  localparam int         BGR_BIT    = 12;    // subpixel_order_swap
  localparam int         GS_BIT     = 15;    // gate_scan_reverse
  localparam logic [7:0] REG_OFS [NREG] = '{
    8'h01, 8'h02, 8'h03, 8'h04, 8'h07, 8'h08, 8'h09, 8'h0a, 8'h0c, 8'h0d,
    8'h0f, 8'h10, 8'h11, 8'h12, 8'h13, 8'h20, 8'h21, 8'h29, 8'h2b, 8'h30,
    8'h31, 8'h32, 8'h35, 8'h36, 8'h37, 8'h38, 8'h39, 8'h3c, 8'h3d, 8'h50,
    8'h51, 8'h52, 8'h53, 8'h60, 8'h61, 8'h6a, 8'h80, 8'h81, 8'h82, 8'h83,
    8'h84, 8'h85, 8'h90, 8'h92, 8'h95, 8'h97};
  // writable bits; all others read back their reset value
  localparam logic [15:0] REG_MASK [NREG] = '{
    16'h0500, 16'h0300, 16'hd0b8, 16'h0333, 16'h313b, 16'h0f0f, 16'h073f,
    16'h000f, 16'h7133, 16'h01ff, 16'h001b, 16'h17f3, 16'h0777, 16'h008f,
    16'h1f00, 16'h00ff, 16'h01ff, 16'h001f, 16'h000f, 16'h0707, 16'h0707,
    16'h0707, 16'h0707, 16'h1f1f, 16'h0707, 16'h0707, 16'h0707, 16'h0707,
    16'h1f1f, 16'h00ff, 16'h00ff, 16'h01ff, 16'h01ff, 16'hbf3f, 16'h0007,
    16'h01ff, 16'h01ff, 16'h01ff, 16'h01ff, 16'h01ff, 16'h01ff, 16'h01ff,
    16'h031f, 16'h0700, 16'h033f, 16'h0f00};
  localparam logic [15:0] REG_RST [NREG] = '{
    16'h0000, 16'h0400, 16'h0030, 16'h0000, 16'h0000, 16'h0808, 16'h0003,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0040, 16'h0770, 16'h0010,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h000b, 16'h0004, 16'h0306,
    16'h0003, 16'h0303, 16'h0e02, 16'h0407, 16'h0104, 16'h0307, 16'h0302,
    16'h0409, 16'h0000, 16'h00ef, 16'h0000, 16'h013f, 16'h2700, 16'h0000,
    16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0010, 16'h0600, 16'h021c, 16'h0c00};

  // ****************************************************************
  // panel geometry
  // ****************************************************************
  localparam logic [8:0]  GATE_LINES = 9'd320;
  localparam logic [8:0]  GATE_HALF  = 9'd160;
  localparam logic [9:0]  SRC_COLS   = 10'd720;

endpackage : lcd_cmd_pkg

// ### src/lcd_cmd_regs.sv
`timescale 1ns/1ps
`default_nettype none

// How it works
// - all parallel widths and serial carry commands
// - select-low write loads index from low byte
// - select-low read returns sixteen-bit identification
// - identification fixed by option, never writable
// - shift bit zero S1 first, else S720
// - shift and swap bits pick colour mapping
// - non-interlaced gates run forward or backward
// - interlaced gates run odd then even, or even then odd when reversed
// - select low index/status, high control register
// - chip select high ignores the bus
// - parallel write starts with strobe low
// - serial data sampled on clock rising edge
module lcd_cmd_regs
  import lcd_cmd_pkg::*;
(
  input  wire logic        MCLK_I,            // block clock, 25 MHz
  input  wire logic        RST_N_I,           // async reset, active low
  input  wire logic        CS_N_I,            // chip select pin, low active
  input  wire logic        RS_I,              // register_select pin
  input  wire logic        WR_N_SCL_I,        // write strobe or serial clock
  input  wire logic        RD_N_I,            // read strobe pin, low active
  input  wire logic        SERIAL_IN_I,       // serial_in pin
  input  wire logic [2:0]  IM_I,              // interface mode strap pins
  input  wire logic [17:0] DB_I,              // data bus pin level
  input  wire logic        LINE_STEP_I,       // advance gate line, one cycle
  input  wire logic        FRAME_START_I,     // restart gate scan, one cycle
  input  wire logic        COL_STEP_I,        // advance source column
  output logic [17:0]      DB_O,              // data bus drive value
  output logic             DB_OE_O,           // data bus drive enable
  output logic             SDO_O,             // serial read data
  output logic             SOURCE_REVERSE_O,  // source shift direction
  output logic             SUBPIXEL_SWAP_O,   // subpixel_order_swap
  output logic [1:0]       COLOR_MAP_O,       // colour filter mapping
  output logic             GATE_INTERLACE_O,  // gate_interlace_scan
  output logic             GATE_REVERSE_O,    // gate_scan_reverse
  output logic [8:0]       GATE_NUM_O,        // active gate, 1..320
  output logic [9:0]       SOURCE_NUM_O       // active source, 1..720
);
  import lcd_cmd_pkg::*;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [PIN_W-1:0] meta_ff;
  logic [PIN_W-1:0] pin_ff;
  logic             wr_n_d_ff;
  logic             rd_n_d_ff;

  // two flops on every pin; only pin_ff is looked at
  always_ff @(posedge MCLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      meta_ff <= {PIN_W{1'b1}};
      pin_ff  <= {PIN_W{1'b1}};
    end
    else
    begin
      meta_ff <= {CS_N_I, RS_I, WR_N_SCL_I, RD_N_I, SERIAL_IN_I, IM_I, DB_I};
      pin_ff  <= meta_ff;
    end
  end

  logic        cs_n;
  logic        rs;
  logic        wr_n;
  logic        rd_n;
  logic        serial_in;
  logic [2:0]  im;
  logic [17:0] db;
  assign cs_n = pin_ff[25];
  assign rs   = pin_ff[24];
  assign wr_n = pin_ff[23];
  assign rd_n = pin_ff[22];
  assign serial_in  = pin_ff[21];
  assign im   = pin_ff[20:18];
  assign db   = pin_ff[17:0];

  // previous strobe levels for edge detection
  always_ff @(posedge MCLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      wr_n_d_ff <= 1'b1;
      rd_n_d_ff <= 1'b1;
    end
    else
    begin
      wr_n_d_ff <= wr_n;
      rd_n_d_ff <= rd_n;
    end
  end

  logic is_serial;
  logic narrow;
  logic wr_rise;
  logic rd_fall;
  logic rd_rise;
  assign is_serial = (im == IM_SERIAL);
  assign narrow    = (im == IM_PAR8) || (im == IM_PAR9);
  // strobe edges count only with chip select low
  assign wr_rise   = !cs_n && wr_n && !wr_n_d_ff;
  assign rd_fall   = !cs_n && !rd_n && rd_n_d_ff && !is_serial;
  assign rd_rise   = !cs_n && rd_n && !rd_n_d_ff && !is_serial;

  // ****************************************************************
  // parallel byte pairing
  // ****************************************************************
  logic       half_ff;
  logic [7:0] hi_byte_ff;

  // narrow ports move a word as two bytes, upper first
  always_ff @(posedge MCLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      half_ff    <= 1'b0;
      hi_byte_ff <= 8'h00;
    end
    else if (cs_n || !narrow || is_serial)
      half_ff <= 1'b0;                        // resync on deselect
    else if ((wr_rise && !is_serial) || rd_rise)
    begin
      half_ff <= !half_ff;
      if (wr_rise && !half_ff)
        hi_byte_ff <= db[17:10];
    end
  end

  // ****************************************************************
  // serial frame receiver
  // ****************************************************************
  logic [4:0]  spi_cnt_ff;
  logic [15:0] spi_sh_ff;
  logic        spi_rs_ff;
  logic        spi_rw_ff;
  logic        spi_ok_ff;
  logic [15:0] sdo_sh_ff;
  logic        scl_rise;
  logic        spi_done;
  logic [7:0]  spi_hdr;
  logic [15:0] reg_sel_val;
  assign scl_rise = wr_rise && is_serial;
  assign spi_done = scl_rise && (spi_cnt_ff == SPI_WORD_LAST) && spi_ok_ff;
  assign spi_hdr  = {spi_sh_ff[6:0], serial_in};

  // start byte: id, register_select, read/write; then sixteen bits
  always_ff @(posedge MCLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      spi_cnt_ff <= 5'h00;
      spi_sh_ff  <= 16'h0000;
      spi_rs_ff  <= 1'b0;
      spi_rw_ff  <= 1'b0;
      spi_ok_ff  <= 1'b0;
    end
    else if (cs_n)
      spi_cnt_ff <= 5'h00;
    else if (scl_rise)
    begin
      spi_sh_ff <= {spi_sh_ff[14:0], serial_in};
      if (spi_cnt_ff == SPI_HDR_LAST)
      begin
        spi_ok_ff  <= (spi_hdr[7:2] == SPI_START_ID);
        spi_rs_ff  <= spi_hdr[1];
        spi_rw_ff  <= spi_hdr[0];
        spi_cnt_ff <= spi_cnt_ff + 5'h01;
      end
      else if (spi_cnt_ff == SPI_WORD_LAST)
        spi_cnt_ff <= SPI_WORD_FIRST;          // consecutive words
      else
        spi_cnt_ff <= spi_cnt_ff + 5'h01;
    end
  end

  // serial read data: loaded after the start byte, shifted per edge
  always_ff @(posedge MCLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      sdo_sh_ff <= 16'h0000;
    else if (scl_rise && spi_cnt_ff == SPI_HDR_LAST && spi_hdr[0])
      sdo_sh_ff <= spi_hdr[1] ? reg_sel_val : ID_CODE;
    else if (scl_rise && spi_cnt_ff == SPI_WORD_LAST && spi_rw_ff)
      sdo_sh_ff <= spi_rs_ff ? reg_sel_val : ID_CODE;
    else if (scl_rise)
      sdo_sh_ff <= {sdo_sh_ff[14:0], 1'b0};
  end

  // ****************************************************************
  // common commit path
  // ****************************************************************
  logic        cmt_go;
  logic        cmt_rs;
  logic [15:0] cmt_data;

  // one commit per completed word, whatever the port width
  always_comb
  begin
    cmt_go   = 1'b0;
    cmt_rs   = rs;
    cmt_data = {db[17:10], db[8:1]};
    if (is_serial)
    begin
      cmt_go   = spi_done && !spi_rw_ff;
      cmt_rs   = spi_rs_ff;
      cmt_data = {spi_sh_ff[14:0], serial_in};
    end
    else if (wr_rise)
    begin
      if (narrow)
      begin
        cmt_go   = half_ff;
        cmt_data = {hi_byte_ff, db[17:10]};
      end
      else
        cmt_go = 1'b1;
    end
  end

  // ****************************************************************
  // index and control registers
  // ****************************************************************
  logic [7:0]  index_ff;
  logic [15:0] reg_ff [NREG];

  // index holds across data accesses; upper byte is dropped
  always_ff @(posedge MCLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      index_ff <= 8'h00;
    else if (cmt_go && !cmt_rs)
      index_ff <= cmt_data[7:0];
  end

  // fixed bits keep their default even if the host writes them
  for (genvar g = 0; g < NREG; g++)
  begin : g_reg
    always_ff @(posedge MCLK_I or negedge RST_N_I)
    begin
      if (!RST_N_I)
        reg_ff[g] <= REG_RST[g];
      else if (cmt_go && cmt_rs && index_ff == REG_OFS[g])
        reg_ff[g] <= (cmt_data & REG_MASK[g]) | (REG_RST[g] & ~REG_MASK[g]);
    end
  end

  // selected register readback; index 00h is the read-only id
  always_comb
  begin
    reg_sel_val = 16'h0000;
    if (index_ff == OFS_ID)
      reg_sel_val = ID_CODE;
    for (int i = 0; i < NREG; i++)
      if (index_ff == REG_OFS[i])
        reg_sel_val = reg_ff[i];
  end

  // ****************************************************************
  // parallel read path
  // ****************************************************************
  logic [15:0] rd_word_ff;
  logic [17:0] db_o_ff;
  logic        db_oe_ff;

  // latch the word on the strobe's leading edge; second byte reuses it
  always_ff @(posedge MCLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
      rd_word_ff <= 16'h0000;
    else if (rd_fall && !(narrow && half_ff))
      rd_word_ff <= rs ? reg_sel_val : ID_CODE;
  end

  // bus drive lags the pins by the synchroniser depth plus one register
  always_ff @(posedge MCLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      db_o_ff  <= 18'h00000;
      db_oe_ff <= 1'b0;
    end
    else
    begin
      db_oe_ff <= !is_serial && !cs_n && !rd_n;
      if (narrow)
        db_o_ff <= {(half_ff ? rd_word_ff[7:0] : rd_word_ff[15:8]), 10'h000};
      else
        db_o_ff <= {rd_word_ff[15:8], 1'b0, rd_word_ff[7:0], 1'b0};
    end
  end

  // ****************************************************************
  // scan direction outputs
  // ****************************************************************
  logic       ss_bit;
  logic       bgr_bit;
  logic       sm_bit;
  logic       gs_bit;
  logic [8:0] line_cnt_ff;
  logic [9:0] col_cnt_ff;
  logic [8:0] gate_num_ff;
  logic [9:0] src_num_ff;
  logic [1:0] color_map_ff;
  logic [8:0] gate_next;
  assign ss_bit  = reg_ff[IDX_DRV][SS_BIT];
  assign sm_bit  = reg_ff[IDX_DRV][SM_BIT];
  assign bgr_bit = reg_ff[IDX_ENTRY][BGR_BIT];
  assign gs_bit  = reg_ff[IDX_GATE][GS_BIT];

  // line and column positions driven by the panel timing logic
  always_ff @(posedge MCLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      line_cnt_ff <= 9'h000;
      col_cnt_ff  <= 10'h000;
    end
    else
    begin
      if (FRAME_START_I || (LINE_STEP_I && line_cnt_ff == GATE_LINES - 9'd1))
        line_cnt_ff <= 9'h000;
      else if (LINE_STEP_I)
        line_cnt_ff <= line_cnt_ff + 9'd1;
      if (LINE_STEP_I || (COL_STEP_I && col_cnt_ff == SRC_COLS - 10'd1))
        col_cnt_ff <= 10'h000;
      else if (COL_STEP_I)
        col_cnt_ff <= col_cnt_ff + 10'd1;
    end
  end

  // gate order from interlace and reverse bits
  always_comb
  begin
    gate_next = line_cnt_ff + 9'd1;
    unique case ({sm_bit, gs_bit})
      2'b00: gate_next = line_cnt_ff + 9'd1;
      2'b01: gate_next = GATE_LINES - line_cnt_ff;
      2'b10: gate_next = (line_cnt_ff < GATE_HALF)
                         ? 9'({line_cnt_ff, 1'b0} + 10'd1)
                         : 9'({line_cnt_ff, 1'b0} - 10'd318);
      2'b11: gate_next = (line_cnt_ff < GATE_HALF)
                         ? 9'(10'd320 - {line_cnt_ff, 1'b0})
                         : 9'(10'd639 - {line_cnt_ff, 1'b0});
    endcase
  end

  // gate, source and colour map outputs registered one cycle after their inputs; interlace and reverse come straight from the registers
  always_ff @(posedge MCLK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      gate_num_ff  <= 9'h001;
      src_num_ff   <= 10'h001;
      color_map_ff <= 2'b00;
    end
    else
    begin
      gate_num_ff  <= gate_next;
      src_num_ff   <= ss_bit ? SRC_COLS - col_cnt_ff : col_cnt_ff + 10'd1;
      color_map_ff <= {ss_bit, bgr_bit};
    end
  end

  assign DB_O             = db_o_ff;
  assign DB_OE_O          = db_oe_ff;
  assign SDO_O            = sdo_sh_ff[15];
  assign SOURCE_REVERSE_O = color_map_ff[1];
  assign SUBPIXEL_SWAP_O  = color_map_ff[0];
  assign COLOR_MAP_O      = color_map_ff;
  assign GATE_INTERLACE_O = reg_ff[IDX_DRV][SM_BIT];
  assign GATE_REVERSE_O   = reg_ff[IDX_GATE][GS_BIT];
  assign GATE_NUM_O       = gate_num_ff;
  assign SOURCE_NUM_O     = src_num_ff;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RST_N_I);

  a_index_load: assert property (cmt_go && !cmt_rs |=> index_ff == $past(cmt_data[7:0]))
    else $error("index not loaded from low byte");
  a_index_hold: assert property (cmt_go && cmt_rs |=> $stable(index_ff))
    else $error("index moved on data access");
  a_identification_code: assert property (rd_fall && !rs && !half_ff |=> rd_word_ff == ID_CODE)
    else $error("identification_code wrong");
  a_id_fixed: assert property (cmt_go && cmt_rs && index_ff == OFS_ID |=> reg_sel_val == ID_CODE)
    else $error("id changed by write");
  a_cs_ignore: assert property (cs_n [*2] |=> !db_oe_ff && !cmt_go)
    else $error("bus used while deselected");
  a_par_write: assert property (!is_serial && !narrow && wr_rise |-> cmt_go)
    else $error("wide write not taken");
  a_narrow_pair: assert property (narrow && !is_serial && wr_rise && !half_ff |-> !cmt_go ##1 half_ff)
    else $error("narrow first byte committed");
  a_spi_count: assert property (scl_rise && !cs_n && spi_cnt_ff == 5'h03 |=> spi_cnt_ff == 5'h04)
    else $error("serial bit not counted");
  a_reg_write: assert property (cmt_go && cmt_rs && index_ff == OFS_DRV_DIR |=> reg_ff[IDX_DRV] == ($past(cmt_data) & REG_MASK[IDX_DRV]))
    else $error("driver direction write lost");
  a_src_dir: assert property (##1 src_num_ff == ($past(ss_bit) ? SRC_COLS - $past(col_cnt_ff) : $past(col_cnt_ff) + 10'd1))
    else $error("source order wrong");
  a_color_map: assert property (##1 COLOR_MAP_O == {$past(ss_bit), $past(bgr_bit)})
    else $error("colour mapping wrong");
  a_gate_seq: assert property (!sm_bit && gs_bit && line_cnt_ff == 9'd0 |=> gate_num_ff == 9'd320)
    else $error("reverse gate start wrong");
  a_gate_ilace: assert property (sm_bit && !gs_bit && line_cnt_ff == GATE_HALF |=> gate_num_ff == 9'd2)
    else $error("interlace even start wrong");
  a_reset_dflt: assert property ($rose(RST_N_I) |-> reg_ff[IDX_GATE] == REG_RST[IDX_GATE])
    else $error("default not restored");

  c_wide_write: cover property (!narrow && !is_serial && cmt_go && cmt_rs);
  c_narrow_pair: cover property (narrow && cmt_go);
  c_spi_write: cover property (is_serial && cmt_go);
  c_par_read: cover property (rd_fall ##[1:20] db_oe_ff);

endmodule : lcd_cmd_regs

`default_nettype wire

// ### tb/lcd_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// host processor model on the strobe and serial pins
// ****************************************************************
module lcd_host_model
  import lcd_cmd_pkg::*;
(
  input  wire logic        clk_i,     // block clock
  input  wire logic [17:0] dev_db_i,  // device drive value
  input  wire logic        dev_oe_i,  // device drive enable
  input  wire logic        dev_sdo_i, // device serial read data
  output logic             cs_n_o,    // chip select
  output logic             rs_o,      // register_select
  output logic             wr_n_o,    // write strobe or serial clock
  output logic             rd_n_o,    // read strobe
  output logic             sdi_o,     // serial_in
  output logic [2:0]       im_o,      // mode straps
  output logic [17:0]      db_o       // resolved bus level
);
  logic [17:0] drv;
  logic        desel;

  // resolved bus: device wins while it drives
  assign db_o = dev_oe_i ? dev_db_i : drv;

  initial
  begin
    cs_n_o = 1'b1;
    rs_o = 1'b0;
    wr_n_o = 1'b1;
    rd_n_o = 1'b1;
    sdi_o = 1'b0;
    im_o = IM_PAR18;
    drv = 18'h00000;
    desel = 1'b0;
  end

  // straps change only while deselected, which also clears byte pairing
  task automatic set_mode(input logic [2:0] m);
    @(posedge clk_i);
    cs_n_o <= 1'b1;
    im_o <= m;
    repeat (6) @(posedge clk_i);
  endtask

  // one strobe, five clocks each way to clear the synchroniser
  task automatic strobe(input logic rs, input logic rd, input logic [17:0] d,
                        output logic [17:0] q);
    @(posedge clk_i);
    rs_o <= rs;
    drv <= rd ? ~drv : d;  // a released bus never shows the old value
    cs_n_o <= desel;
    if (rd)
      rd_n_o <= 1'b0;
    else
      wr_n_o <= 1'b0;
    repeat (5) @(posedge clk_i);
    q = dev_oe_i ? dev_db_i : ~dev_db_i;  // undriven bus never matches
    rd_n_o <= 1'b1;
    wr_n_o <= 1'b1;
    repeat (5) @(posedge clk_i);
  endtask

  // whole word: one strobe when wide, upper byte then lower when narrow
  task automatic access(input logic rs, input logic rd, input logic [15:0] w,
                        output logic [15:0] q);
    logic [17:0] a;
    logic [17:0] b;
    if (im_o == IM_PAR8 || im_o == IM_PAR9)
    begin
      strobe(rs, rd, {w[15:8], 10'h000}, a);
      strobe(rs, rd, {w[7:0], 10'h000}, b);
      q = {a[17:10], b[17:10]};
    end
    else
    begin
      strobe(rs, rd, {w[15:8], 1'b0, w[7:0], 1'b0}, a);
      q = {a[17:10], a[8:1]};
    end
  endtask

  // start byte then one word, msb first; the clock idles high;
  // read data is taken just before each data bit's clock falls
  task automatic serial(input logic rs, input logic rw, input logic [15:0] w,
                        output logic [15:0] q);
    logic [23:0] f;
    f = {SPI_START_ID, rs, rw, w};
    q = 16'h0000;
    @(posedge clk_i);
    cs_n_o <= 1'b0;
    for (int i = 23; i >= 0; i--)
    begin
      @(posedge clk_i);
      if (i < 16)
        q[i] = dev_sdo_i;
      wr_n_o <= 1'b0;
      sdi_o <= f[i];
      repeat (3) @(posedge clk_i);
      wr_n_o <= 1'b1;
      repeat (3) @(posedge clk_i);
    end
    repeat (4) @(posedge clk_i);
    cs_n_o <= 1'b1;
    sdi_o <= ~sdi_o;
    repeat (4) @(posedge clk_i);
  endtask
endmodule // lcd_host_model

`default_nettype wire

// ### tb/lcd_driver_command_registers_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(nm, ex, gt) \
  begin \
    total_checks++; \
    if ((gt) !== (ex)) \
    begin \
      miscompares++; \
      $display("[ERR] %s expected %h seen %h", nm, ex, gt); \
    end \
  end

module lcd_driver_command_registers_tb_top;
  import lcd_cmd_pkg::*;
  typedef struct packed {logic [7:0] idx; logic [15:0] wr; logic [15:0] ex;} row_t;

  // ****************************************************************
  // write then read back: fixed bits, unmapped and identification
  // ****************************************************************
  localparam row_t ROWS [7] = '{
    '{8'h01, 16'hffff, 16'h0500}, '{8'h03, 16'hffff, 16'hd0b8},
    '{8'h60, 16'hffff, 16'hbf3f}, '{8'h02, 16'h0000, 16'h0400},
    '{8'h0d, 16'hffff, 16'h01ff}, '{8'h05, 16'hffff, 16'h0000},
    '{8'h00, 16'h1234, ID_CODE}};

  logic mclk, rst_n, cs_n, rs, wr_n, rd_n, serial_in, db_oe;
  logic [2:0] im;
  logic [2:0] steps;
  logic [17:0] db_i, db_o;
  logic [15:0] q;
  logic [1:0] cmap;
  logic [8:0] gate;
  logic [9:0] src;
  logic src_rev, swap, ilace, grev, sdo;
  int miscompares = 0;
  int total_checks = 0;

  lcd_cmd_regs uut
  (
    .MCLK_I(mclk), .RST_N_I(rst_n), .CS_N_I(cs_n), .RS_I(rs), .WR_N_SCL_I(wr_n),
    .RD_N_I(rd_n), .SERIAL_IN_I(serial_in), .IM_I(im), .DB_I(db_i),
    .LINE_STEP_I(steps[1]), .FRAME_START_I(steps[2]), .COL_STEP_I(steps[0]),
    .DB_O(db_o), .DB_OE_O(db_oe), .SDO_O(sdo), .SOURCE_REVERSE_O(src_rev),
    .SUBPIXEL_SWAP_O(swap), .COLOR_MAP_O(cmap), .GATE_INTERLACE_O(ilace),
    .GATE_REVERSE_O(grev), .GATE_NUM_O(gate), .SOURCE_NUM_O(src)
  );

  lcd_host_model host
  (
    .clk_i(mclk), .dev_db_i(db_o), .dev_oe_i(db_oe), .cs_n_o(cs_n), .rs_o(rs),
    .wr_n_o(wr_n), .rd_n_o(rd_n), .sdi_o(serial_in), .im_o(im), .db_o(db_i), .dev_sdo_i(sdo)
  );

  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end

  // index first with junk in the upper byte, then the data word
  task automatic wr_reg(input logic [7:0] idx, input logic [15:0] w);
    host.access(1'b0, 1'b0, {8'ha5, idx}, q);
    host.access(1'b1, 1'b0, w, q);
  endtask

  task automatic rd_reg(input logic [7:0] idx);
    host.access(1'b0, 1'b0, {8'h5a, idx}, q);
    host.access(1'b1, 1'b1, 16'h0000, q);
  endtask

  // one-cycle scan pulse, then time for counter and output to settle
  task automatic pulse(input logic [2:0] m);
    @(posedge mclk);
    steps <= m;
    @(posedge mclk);
    steps <= 3'h0;
    repeat (2) @(posedge mclk);
  endtask

  // expected gate for scan position n, worked from the scan order tables
  function automatic logic [8:0] gate_at(input logic sm, input logic gs, input int n);
    int g;
    g = sm ? (n < 160 ? 2 * n + 1 : 2 * (n - 160) + 2) : n + 1;
    return 9'(gs ? 321 - g : g);
  endfunction

  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // generous bound: the whole sequence needs about 5300 clocks
  initial
  begin
    repeat (60000) @(posedge mclk);
    miscompares++;
    final_report();
  end

  initial
  begin
    rst_n = 1'b0;
    steps = 3'h0;
    repeat (3) @(posedge mclk);
    rst_n <= 1'b1;
    host.set_mode(IM_PAR18);
    for (int i = 0; i < NREG; i++)
    begin
      rd_reg(REG_OFS[i]);
      `CHK("reset value", REG_RST[i], q)
    end
    host.access(1'b0, 1'b1, 16'h0000, q);
    `CHK("id with select low", ID_CODE, q)
    host.set_mode(IM_PAR16);
    for (int i = 0; i < 7; i++)
    begin
      wr_reg(ROWS[i].idx, ROWS[i].wr);
      rd_reg(ROWS[i].idx);
      `CHK("readback", ROWS[i].ex, q)
    end
    // data-only accesses keep hitting the last index
    wr_reg(8'h0d, 16'h0055);
    host.access(1'b1, 1'b0, 16'h00aa, q);
    host.access(1'b1, 1'b1, 16'h0000, q);
    `CHK("index kept", 16'h00aa, q)
    host.desel = 1'b1;
    wr_reg(8'h0d, 16'h0011);
    host.desel = 1'b0;
    rd_reg(8'h0d);
    `CHK("deselected write", 16'h00aa, q)
    host.set_mode(IM_PAR8);
    wr_reg(8'h21, 16'h01a5);
    rd_reg(8'h21);
    `CHK("byte port", 16'h01a5, q)
    host.set_mode(IM_PAR9);
    wr_reg(8'h21, 16'h015a);
    rd_reg(8'h21);
    `CHK("nine-bit port", 16'h015a, q)
    host.set_mode(IM_SERIAL);
    host.serial(1'b0, 1'b0, 16'h0020, q);
    host.serial(1'b1, 1'b0, 16'h00c3, q);
    host.serial(1'b1, 1'b1, 16'h0000, q);
    `CHK("serial read", 16'h00c3, q)
    host.serial(1'b0, 1'b1, 16'h0000, q);
    `CHK("serial id", ID_CODE, q)
    host.set_mode(IM_PAR16);
    rd_reg(8'h20);
    `CHK("serial write", 16'h00c3, q)
    // each pass rewrites all three registers in full, as a host must redo display data
    for (int c = 0; c < 4; c++)
    begin
      wr_reg(8'h01, {5'h00, c[1], 1'b0, c[0], 8'h00});
      wr_reg(8'h03, {3'h0, c[1] ^ c[0], 12'h030});
      wr_reg(8'h60, {c[0], 15'h2700});
      `CHK("colour map", {c[0], c[1] ^ c[0]}, cmap)
      `CHK("swap", c[1] ^ c[0], swap)
      `CHK("source reverse", c[0], src_rev)
      `CHK("interlace", c[1], ilace)
      `CHK("gate reverse", c[0], grev)
      pulse(3'h4);
      `CHK("first gate", gate_at(c[1], c[0], 0), gate)
      pulse(3'h2);
      `CHK("second gate", gate_at(c[1], c[0], 1), gate)
      `CHK("first source", 10'(c[0] ? 720 : 1), src)
      pulse(3'h1);
      `CHK("second source", 10'(c[0] ? 719 : 2), src)
      for (int n = 2; n <= 160; n++)
        pulse(3'h2);
      `CHK("mid gate", gate_at(c[1], c[0], 160), gate)
    end
    // reset in mid-run: outputs at defaults while held, index back to 00h
    rst_n <= 1'b0;
    repeat (3) @(posedge mclk);
    `CHK("gate in reset", 9'h001, gate)
    `CHK("map in reset", 2'b00, cmap)
    rst_n <= 1'b1;
    host.set_mode(IM_PAR16);
    host.access(1'b1, 1'b1, 16'h0000, q);
    `CHK("index after reset", ID_CODE, q)
    rd_reg(8'h60);
    `CHK("default after reset", REG_RST[IDX_GATE], q)
    final_report();
  end
endmodule // lcd_driver_command_registers_tb_top

`default_nettype wire
